/* design/mie_exec.sv */
// instruction executor for a subset of an 8-bit core, reached over apb
// assumes an apb master on clk; one command register write starts one instruction
//
// Implementation choices: the APB register port and the address map.
`timescale 1ns/10ps
`include "mie_consts.svh"

module mie_exec import mie_pkg::*; #(
  parameter int PC_W = 16,
  parameter int MEM_AW = 6,
  parameter int STK_DEPTH = 8,
  parameter int WDT_W = 8,
  parameter int WDT_DIV = `MIE_WDT_DIV
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic clk_gate_off,
  output logic busy
);
  localparam int SP_W = $clog2(STK_DEPTH);

  if (PC_W < 9 || PC_W > 16 || MEM_AW < 4 || MEM_AW > 8 || WDT_W < 2 || WDT_W > 16 ||
      STK_DEPTH < 2 || (1 << SP_W) != STK_DEPTH || WDT_DIV < 2 || WDT_DIV > 65536) begin : g_chk
    $error("mie_exec: unsupported parameter values");
  end

  // ************************************************************
  // architectural state
  // ************************************************************
  logic [7:0] acc;
  mie_flags_t fl;
  logic [PC_W-1:0] pc;
  logic [PC_W-1:0] target;
  logic [7:0] mem_ptr;
  logic [7:0] mem [0:(1<<MEM_AW)-1];
  logic [PC_W-1:0] stk [0:STK_DEPTH-1];
  logic [SP_W-1:0] sp;
  logic pre1;
  logic pre2;
  logic halted;
  logic [WDT_W-1:0] wdt;
  logic [15:0] presc;
  mie_state_t state;
  logic [3:0] cnt;
  wire wdt_tick = ~halted & (presc == 16'(WDT_DIV - 1));
  wire wdt_ovf = wdt_tick & (&wdt);

  // ************************************************************
  // apb decode
  // ************************************************************
  wire setup = psel & ~penable;
  wire access = psel & penable;
  wire wr = access & pwrite;
  wire hit_cmd = paddr == `MIE_REG_CMD;
  wire hit_acc = paddr == `MIE_REG_ACC;
  wire hit_fl = paddr == `MIE_REG_FLAGS;
  wire hit_pc = paddr == `MIE_REG_PC;
  wire hit_st = paddr == `MIE_REG_STATUS;
  wire hit_ma = paddr == `MIE_REG_MEMADDR;
  wire hit_md = paddr == `MIE_REG_MEMDATA;
  wire hit_tg = paddr == `MIE_REG_TARGET;
  wire hit_wk = paddr == `MIE_REG_WAKE;
  wire hit_sk = paddr == `MIE_REG_STACKTOP;
  wire mapped = hit_cmd | hit_acc | hit_fl | hit_pc | hit_st | hit_ma | hit_md | hit_tg | hit_wk | hit_sk;
  wire idle = (state == MIE_IDLE) & ~halted;
  // software state writes other than wake are dropped unless idle, so a running instruction is never torn
  wire sw_wr = wr & idle;

  assign pready = 1'b1;
  assign pslverr = access & ~mapped;
  assign clk_gate_off = halted;
  assign busy = state == MIE_RUN;

  // ************************************************************
  // operand path
  // ************************************************************
  mie_cmd_t nc;
  assign nc = mie_cmd_t'(pwdata);
  wire [MEM_AW-1:0] ex_idx = nc.maddr[MEM_AW-1:0];
  wire [7:0] mem_rd = mem[ex_idx];
  wire imm_form = (nc.op == MIE_SUM_IMM_TO_ACC) | (nc.op == MIE_CONJ_IMM_TO_ACC);
  wire [7:0] opb = imm_form ? nc.imm : mem_rd;
  wire cin_use = (nc.op == MIE_SUM_CARRY_TO_ACC) | (nc.op == MIE_SUM_CARRY_TO_MEM);
  wire cin = cin_use & fl.high_bit_out_flag;
  wire [8:0] sum9 = {1'b0, acc} + {1'b0, opb} + {8'h00, cin};
  wire [4:0] half5 = {1'b0, acc[3:0]} + {1'b0, opb[3:0]} + {4'h0, cin};
  wire ovf = (acc[7] == opb[7]) & (sum9[7] != acc[7]);
  wire [7:0] conj = acc & opb;
  wire [7:0] inv = ~mem_rd;
  wire [7:0] dec8 = mem_rd - 8'h01;
  wire [7:0] inc8 = mem_rd + 8'h01;
  wire [7:0] clrbit = mem_rd & ~(8'h01 << nc.bitsel);

  mie_flags_t arith_fl;
  assign arith_fl.watchdog_expiry_flag = fl.watchdog_expiry_flag;
  assign arith_fl.sleep_entered_flag = fl.sleep_entered_flag;
  assign arith_fl.signed_wrap_flag = ovf;
  assign arith_fl.result_null_flag = sum9[7:0] == 8'h00;
  assign arith_fl.half_wrap_flag = half5[4];
  assign arith_fl.high_bit_out_flag = sum9[8];

  // decimal adjust: accumulator nibbles into the memory byte
  wire low_adj = (acc[3:0] > 4'h9) | fl.half_wrap_flag;
  wire [4:0] low5 = {1'b0, acc[3:0]} + (low_adj ? 5'h06 : 5'h00);
  wire low_nibble_adjust_out = low5[4];
  wire [4:0] hi5 = {1'b0, acc[7:4]} + {4'h0, low_nibble_adjust_out};
  wire hi_adj = (hi5 > 5'h09) | fl.high_bit_out_flag;
  wire [4:0] hi_res = hi_adj ? hi5 + 5'h06 : hi5;

  wire [PC_W-1:0] pc_inc = PC_W'(pc + 1'b1);

  // ************************************************************
  // instruction decode
  // ************************************************************
  logic op_ok;
  logic [7:0] next_acc;
  mie_flags_t next_fl;
  logic mem_we;
  logic [7:0] mem_wd;
  logic jump;
  logic next_pre1;
  logic next_pre2;
  logic wdt_clr;
  logic go_sleep;

  always_comb begin
    op_ok = 1'b1;
    next_acc = acc;
    next_fl = fl;
    mem_we = 1'b0;
    mem_wd = mem_rd;
    jump = 1'b0;
    next_pre1 = pre1;
    next_pre2 = pre2;
    wdt_clr = 1'b0;
    go_sleep = 1'b0;
    case (nc.op)
      MIE_SUM_CARRY_TO_ACC, MIE_SUM_TO_ACC, MIE_SUM_IMM_TO_ACC: begin
        next_acc = sum9[7:0];
        next_fl = arith_fl;
      end
      MIE_SUM_CARRY_TO_MEM, MIE_SUM_TO_MEM: begin
        mem_we = 1'b1;
        mem_wd = sum9[7:0];
        next_fl = arith_fl;
      end
      MIE_CONJ_TO_ACC, MIE_CONJ_IMM_TO_ACC: begin
        next_acc = conj;
        next_fl.result_null_flag = conj == 8'h00;
      end
      MIE_CONJ_TO_MEM: begin
        mem_we = 1'b1;
        mem_wd = conj;
        next_fl.result_null_flag = conj == 8'h00;
      end
      MIE_SUBROUTINE_JUMP: begin
        jump = 1'b1;
      end
      MIE_CLEAR_MEM: begin
        mem_we = 1'b1;
        mem_wd = 8'h00;
      end
      MIE_CLEAR_BIT: begin
        mem_we = 1'b1;
        mem_wd = clrbit;
      end
      MIE_WATCHDOG_KICK: begin
        wdt_clr = 1'b1;
        next_pre1 = 1'b0;
        next_pre2 = 1'b0;
        next_fl.sleep_entered_flag = 1'b0;
        next_fl.watchdog_expiry_flag = 1'b0;
      end
      MIE_PRECLEAR_FIRST, MIE_PRECLEAR_SECOND: begin
        // a lone preclear only records itself; the pair completes the clear
        if ((nc.op == MIE_PRECLEAR_FIRST) ? pre2 : pre1) begin
          wdt_clr = 1'b1;
          next_pre1 = 1'b0;
          next_pre2 = 1'b0;
          next_fl.sleep_entered_flag = 1'b0;
          next_fl.watchdog_expiry_flag = 1'b0;
        end else if (nc.op == MIE_PRECLEAR_FIRST) begin
          next_pre1 = 1'b1;
        end else begin
          next_pre2 = 1'b1;
        end
      end
      MIE_INVERT_MEM: begin
        mem_we = 1'b1;
        mem_wd = inv;
        next_fl.result_null_flag = inv == 8'h00;
      end
      MIE_INVERT_TO_ACC: begin
        next_acc = inv;
        next_fl.result_null_flag = inv == 8'h00;
      end
      MIE_DECIMAL_ADJUST: begin
        mem_we = 1'b1;
        mem_wd = {hi_res[3:0], low5[3:0]};
        next_fl.high_bit_out_flag = hi_adj ? 1'b1 : fl.high_bit_out_flag;
      end
      MIE_MINUS_ONE_MEM: begin
        mem_we = 1'b1;
        mem_wd = dec8;
        next_fl.result_null_flag = dec8 == 8'h00;
      end
      MIE_MINUS_ONE_TO_ACC: begin
        next_acc = dec8;
        next_fl.result_null_flag = dec8 == 8'h00;
      end
      MIE_PLUS_ONE_MEM: begin
        mem_we = 1'b1;
        mem_wd = inc8;
        next_fl.result_null_flag = inc8 == 8'h00;
      end
      MIE_POWER_DOWN: begin
        go_sleep = 1'b1;
        wdt_clr = 1'b1;
        next_fl.sleep_entered_flag = 1'b1;
        next_fl.watchdog_expiry_flag = 1'b0;
      end
      default: begin
        op_ok = 1'b0;
      end
    endcase
  end

  wire start = wr & hit_cmd & idle & op_ok;
  wire pcl_hit = mem_we & (nc.maddr == `MIE_PCL_ADDR);
  wire [PC_W-1:0] seq_pc = pcl_hit ? {pc_inc[PC_W-1:8], mem_wd} : pc_inc;
  wire [PC_W-1:0] next_pc = jump ? target : seq_pc;
  // call occupies two cycles, a pc low write one extra
  wire [3:0] busy_len = (jump | pcl_hit) ? 4'(`MIE_BUSY_TWO) : 4'(`MIE_BUSY_ONE);

  // ************************************************************
  // sequencer
  // ************************************************************
  always_ff @(posedge clk) begin
    if (reset) begin
      state <= MIE_IDLE;
      cnt <= 4'h0;
    end else begin
      case (state)
        MIE_IDLE: begin
          if (start) begin
            state <= MIE_RUN;
            cnt <= busy_len;
          end
        end
        MIE_RUN: begin
          cnt <= cnt - 4'h1;
          if (cnt == 4'h0) begin
            state <= MIE_IDLE;
          end
        end
        default: begin
          state <= MIE_IDLE;
          cnt <= 4'h0;
        end
      endcase
    end
  end

  // ************************************************************
  // registers
  // ************************************************************
  always_ff @(posedge clk) begin
    if (reset) begin
      acc <= 8'h00;
      pc <= '0;
      target <= '0;
      mem_ptr <= 8'h00;
    end else if (start) begin
      acc <= next_acc;
      pc <= next_pc;
    end else if (sw_wr) begin
      if (hit_acc) acc <= pwdata[7:0];
      if (hit_pc) pc <= pwdata[PC_W-1:0];
      if (hit_tg) target <= pwdata[PC_W-1:0];
      if (hit_ma) mem_ptr <= pwdata[7:0];
    end
  end

  // expiry set by the watchdog wins over any clear in the same cycle
  always_ff @(posedge clk) begin
    if (reset) begin
      fl <= mie_flags_t'(`MIE_FLAGS_RESET);
    end else begin
      if (start) begin
        fl <= next_fl;
      end else if (sw_wr & hit_fl) begin
        fl <= {fl.watchdog_expiry_flag, fl.sleep_entered_flag, pwdata[3:0]};
      end
      if (wdt_ovf) begin
        fl.watchdog_expiry_flag <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      pre1 <= 1'b0;
      pre2 <= 1'b0;
      halted <= 1'b0;
    end else if (start) begin
      pre1 <= next_pre1;
      pre2 <= next_pre2;
      halted <= go_sleep;
    end else if (wr & hit_wk) begin
      halted <= 1'b0;
    end
  end

  // data memory has no reset: contents survive power down
  always_ff @(posedge clk) begin
    if (start & mem_we) begin
      mem[ex_idx] <= mem_wd;
    end else if (sw_wr & hit_md) begin
      mem[mem_ptr[MEM_AW-1:0]] <= pwdata[7:0];
    end
  end

  // return stack wraps silently when nested too deep
  always_ff @(posedge clk) begin
    if (reset) begin
      sp <= '0;
    end else if (start & jump) begin
      stk[sp] <= pc_inc;
      sp <= SP_W'(sp + 1'b1);
    end
  end

  // ************************************************************
  // watchdog, frozen while the clock is gated off
  // ************************************************************
  always_ff @(posedge clk) begin
    if (reset) begin
      presc <= 16'h0000;
      wdt <= '0;
    end else if (start & wdt_clr) begin
      presc <= 16'h0000;
      wdt <= '0;
    end else if (~halted) begin
      presc <= wdt_tick ? 16'h0000 : presc + 16'h0001;
      if (wdt_tick) wdt <= WDT_W'(wdt + 1'b1);
    end
  end

  // ************************************************************
  // read data, captured in the setup phase
  // ************************************************************
  wire [31:0] st_word = {16'h0000, 16'(wdt) << 8} | {28'h0000000, pre2, pre1, halted, busy};
  wire [31:0] rd_mux =
    hit_acc ? {24'h000000, acc} :
    hit_fl ? {26'h0000000, fl} :
    hit_pc ? 32'(pc) :
    hit_st ? st_word :
    hit_ma ? {24'h000000, mem_ptr} :
    hit_md ? {24'h000000, mem[mem_ptr[MEM_AW-1:0]]} :
    hit_tg ? 32'(target) :
    hit_sk ? 32'(stk[SP_W'(sp - 1'b1)]) :
    32'h00000000;

  always_ff @(posedge clk) begin
    if (reset) begin
      prdata <= 32'h00000000;
    end else if (setup & ~pwrite) begin
      prdata <= rd_mux;
    end
  end
endmodule

/* inc/mie_consts.svh */
// register offsets, reset values and timing counts of the instruction executor
// assumes a 32-bit apb slave with byte addresses in paddr[7:0]
`ifndef MIE_CONSTS_SVH
`define MIE_CONSTS_SVH
`define MIE_REG_CMD 8'h00
`define MIE_REG_ACC 8'h04
`define MIE_REG_FLAGS 8'h08
`define MIE_REG_PC 8'h0C
`define MIE_REG_STATUS 8'h10
`define MIE_REG_MEMADDR 8'h14
`define MIE_REG_MEMDATA 8'h18
`define MIE_REG_TARGET 8'h1C
`define MIE_REG_WAKE 8'h20
`define MIE_REG_STACKTOP 8'h24
`define MIE_FLAGS_RESET 6'h00
`define MIE_PCL_ADDR 8'h06
`define MIE_CLKS_PER_CYCLE 4
`define MIE_BUSY_ONE (`MIE_CLKS_PER_CYCLE * 1 - 1)
`define MIE_BUSY_TWO (`MIE_CLKS_PER_CYCLE * 2 - 1)
`define MIE_WDT_DIV 16
`endif

/* inc/mie_pkg.sv */
// types of the instruction executor: opcodes, flags, command word, states
// assumes nothing beyond a systemverilog compiler
package mie_pkg;
  typedef enum logic [4:0] {
    MIE_SUM_CARRY_TO_ACC = 5'h00,
    MIE_SUM_CARRY_TO_MEM = 5'h01,
    MIE_SUM_TO_ACC = 5'h02,
    MIE_SUM_IMM_TO_ACC = 5'h03,
    MIE_SUM_TO_MEM = 5'h04,
    MIE_CONJ_TO_ACC = 5'h05,
    MIE_CONJ_IMM_TO_ACC = 5'h06,
    MIE_CONJ_TO_MEM = 5'h07,
    MIE_SUBROUTINE_JUMP = 5'h08,
    MIE_CLEAR_MEM = 5'h09,
    MIE_CLEAR_BIT = 5'h0A,
    MIE_WATCHDOG_KICK = 5'h0B,
    MIE_PRECLEAR_FIRST = 5'h0C,
    MIE_PRECLEAR_SECOND = 5'h0D,
    MIE_INVERT_MEM = 5'h0E,
    MIE_INVERT_TO_ACC = 5'h0F,
    MIE_DECIMAL_ADJUST = 5'h10,
    MIE_MINUS_ONE_MEM = 5'h11,
    MIE_MINUS_ONE_TO_ACC = 5'h12,
    MIE_PLUS_ONE_MEM = 5'h13,
    MIE_POWER_DOWN = 5'h14
  } mie_op_t;

  typedef struct packed {
    logic watchdog_expiry_flag;
    logic sleep_entered_flag;
    logic signed_wrap_flag;
    logic result_null_flag;
    logic half_wrap_flag;
    logic high_bit_out_flag;
  } mie_flags_t;

  typedef struct packed {
    logic [7:0] imm;
    logic [7:0] maddr;
    logic [4:0] spare_hi;
    logic [2:0] bitsel;
    logic [2:0] spare_lo;
    mie_op_t op;
  } mie_cmd_t;

  typedef enum logic [1:0] {
    MIE_IDLE = 2'b01,
    MIE_RUN = 2'b10
  } mie_state_t;
endpackage

/* tb/mie_apb_master.sv */
// apb master model standing on the software side of the executor
// assumes the caller enters xfer just after a rising clk edge
`timescale 1ns/10ps
module mie_apb_master (
  input wire logic clk,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end
  // one idle edge after each transfer, so no signal is driven twice in a step
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q, output logic e);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
endmodule

/* tb/mie_exec_properties.sv */
// checker of bus, busy and power-down timing at the executor's ports
// assumes the default instruction cycle of four clocks
`timescale 1ns/10ps
`include "mie_consts.svh"
module mie_exec_checker (
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic clk_gate_off,
  input wire logic busy
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // ****************
  // decode
  // ****************
  wire logic acc_ph = psel && penable;
  wire logic [4:0] op = pwdata[4:0];
  wire logic cmd_go = acc_ph && pwrite && paddr == `MIE_REG_CMD && !busy && !clk_gate_off && op <= 5'h14;
  wire logic mem_wr = op inside {5'h01, 5'h04, 5'h07, 5'h09, 5'h0A, 5'h0E, 5'h10, 5'h11, 5'h13};
  wire logic long_go = cmd_go && (op == 5'h08 || (mem_wr && pwdata[23:16] == `MIE_PCL_ADDR));
  wire logic short_go = cmd_go && !long_go && op != 5'h14;
  wire logic wake_go = acc_ph && pwrite && paddr == `MIE_REG_WAKE;
  wire logic unmapped = paddr > `MIE_REG_STACKTOP || paddr[1:0] != 2'b00;
  // ****************
  // properties
  // ****************
  sequence s_busy4;
    busy [*4] ##1 !busy;
  endsequence
  sequence s_busy8;
    busy [*8] ##1 !busy;
  endsequence
  property p_busy_one; short_go |=> s_busy4; endproperty
  a_busy_one: assert property (p_busy_one) else $error("short instruction busy length wrong");
  property p_busy_two; long_go |=> s_busy8; endproperty
  a_busy_two: assert property (p_busy_two) else $error("long instruction busy length wrong");
  property p_busy_cause; !busy && !cmd_go |=> !busy; endproperty
  a_busy_cause: assert property (p_busy_cause) else $error("busy without a command");
  property p_gate_on; cmd_go && op == 5'h14 |=> clk_gate_off; endproperty
  a_gate_on: assert property (p_gate_on) else $error("power down did not gate clock");
  property p_gate_hold; clk_gate_off && !wake_go |=> clk_gate_off; endproperty
  a_gate_hold: assert property (p_gate_hold) else $error("clock gate dropped without wake");
  property p_wake; clk_gate_off && wake_go |-> ##[1:4] !clk_gate_off; endproperty
  a_wake: assert property (p_wake) else $error("wake did not ungate clock");
  property p_err; pslverr == (acc_ph && unmapped); endproperty
  a_err: assert property (p_err) else $error("slave error does not match address map");
  property p_rd_cmd; psel && !penable && !pwrite && paddr == `MIE_REG_CMD |=> prdata == 32'h0; endproperty
  a_rd_cmd: assert property (p_rd_cmd) else $error("command register read not zero");
endmodule
bind mie_exec mie_exec_checker u_chk (.clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .clk_gate_off(clk_gate_off), .busy(busy));

/* tb/mie_exec_tb.sv */
// self-checking bench of the executor driven through the apb master model
// assumes a 100 ns clock and a fast watchdog prescaler of two
`timescale 1ns/10ps
`include "mie_consts.svh"
module mie_exec_tb;
  // overflow of an 8-bit watchdog behind a divide-by-two prescaler, plus margin
  localparam int WDT_SPAN = 2 * 256 + 40;
  logic clk;
  logic reset;
  wire logic psel, penable, pwrite, pready, pslverr, clk_gate_off, busy;
  wire logic [7:0] paddr;
  wire logic [31:0] pwdata, prdata;
  logic [31:0] rdat;
  logic rerr;
  int err_total = 0;
  int checks_done = 0;
  // op, acc in, mem in, flags in, acc out, mem out, flags out
  logic [55:0] tbl [21] = '{56'h00F80801010803, 56'h01F80801F80103, 56'h02F80801000807, 56'h03F80801000807,
    56'h04F80801F80007, 56'h007F000180000A, 56'h027F00017F0000, 56'h053CA50F24A50B, 56'h063CA50F24A50B,
    56'h073CA50F3C240B, 56'h093CA50F3C000F, 56'h0A3CA50F3C850F, 56'h0E3CA50F3C5A0B, 56'h0F3CA50F5AA50B,
    56'h113CA50F3CA40B, 56'h123CA50FA4A50B, 56'h133CA50F3CA60B, 56'h113C01003C0004, 56'h109AA5009A0001,
    56'h1045A50A454B0A, 56'h1012A501127201};
  mie_exec #(.WDT_DIV(2)) u_dut (.clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .clk_gate_off(clk_gate_off), .busy(busy));
  mie_apb_master u_bus (.clk(clk), .prdata(prdata), .pready(pready), .pslverr(pslverr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
  // ****************
  // tasks
  // ****************
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    u_bus.xfer(1'b1, a, d, q, e);
  endtask
  task rd(input logic [7:0] a);
    u_bus.xfer(1'b0, a, 32'h0, rdat, rerr);
  endtask
  // polls busy; the bound only stops a stuck poll, the assertions judge the length
  task run(input logic [31:0] cmd);
    int n;
    wr(`MIE_REG_CMD, cmd);
    n = 0;
    do begin
      rd(`MIE_REG_STATUS);
      n++;
    end while (rdat[0] !== 1'b0 && n < 20);
    // a poll that runs out is a hang, counted as a mismatch
    if (rdat[0] !== 1'b0) err_total++;
  endtask
  task final_report;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // ****************
  // sequence
  // ****************
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    #(20000 * 100);
    err_total++;
    final_report;
  end
  initial begin
    reset = 1'b1;
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    rd(`MIE_REG_FLAGS);
    chk(rdat, 32'h0);
    foreach (tbl[i]) begin
      wr(`MIE_REG_ACC, {24'h0, tbl[i][47:40]});
      wr(`MIE_REG_MEMADDR, 32'h5);
      wr(`MIE_REG_MEMDATA, {24'h0, tbl[i][39:32]});
      wr(`MIE_REG_FLAGS, {24'h0, tbl[i][31:24]});
      run({tbl[i][39:32], 8'h05, 5'h00, 3'h5, 3'h0, tbl[i][52:48]});
      rd(`MIE_REG_ACC);
      chk(rdat, {24'h0, tbl[i][23:16]});
      rd(`MIE_REG_MEMDATA);
      chk(rdat, {24'h0, tbl[i][15:8]});
      rd(`MIE_REG_FLAGS);
      chk(rdat & 32'h0F, {24'h0, tbl[i][7:0]});
    end
    wr(`MIE_REG_PC, 32'h0123);
    wr(`MIE_REG_TARGET, 32'h0456);
    wr(`MIE_REG_FLAGS, 32'h0A);
    run(32'h08);
    rd(`MIE_REG_PC);
    chk(rdat, 32'h0456);
    rd(`MIE_REG_STACKTOP);
    chk(rdat, 32'h0124);
    rd(`MIE_REG_FLAGS);
    chk(rdat & 32'h0F, 32'h0A);
    run({8'h00, `MIE_PCL_ADDR, 16'h0009});
    rd(`MIE_REG_PC);
    chk(rdat, 32'h0400);
    rd(8'h40);
    chk({31'h0, rerr}, 32'h1);
    run(32'h0B);
    wr(`MIE_REG_FLAGS, 32'h0);
    repeat (WDT_SPAN) @(posedge clk);
    rd(`MIE_REG_FLAGS);
    chk(rdat, 32'h20);
    run(32'h0C);
    rd(`MIE_REG_FLAGS);
    chk(rdat, 32'h20);
    rd(`MIE_REG_STATUS);
    chk(rdat & 32'h4, 32'h4);
    run(32'h0D);
    rd(`MIE_REG_FLAGS);
    chk(rdat, 32'h0);
    wr(`MIE_REG_FLAGS, 32'h05);
    wr(`MIE_REG_ACC, 32'h33);
    wr(`MIE_REG_PC, 32'h0200);
    repeat (WDT_SPAN) @(posedge clk);
    run(32'h14);
    chk({31'h0, clk_gate_off}, 32'h1);
    rd(`MIE_REG_FLAGS);
    chk(rdat, 32'h15);
    rd(`MIE_REG_STATUS);
    chk({24'h0, rdat[15:8]}, 32'h0);
    rd(`MIE_REG_PC);
    chk(rdat, 32'h0201);
    wr(`MIE_REG_ACC, 32'h55);
    rd(`MIE_REG_ACC);
    chk(rdat, 32'h33);
    wr(`MIE_REG_WAKE, 32'h1);
    for (int i = 0; i < 8 && clk_gate_off === 1'b1; i++) @(posedge clk);
    run(32'h0B);
    rd(`MIE_REG_FLAGS);
    chk(rdat, 32'h05);
    final_report;
  end
endmodule
